// ---- shared/accb_pkg.sv ----
// Constants, field layouts and types of the ADC channel configuration bank.
// ==========================================================================
`default_nettype none
package accb_pkg;
  // ========================================================================
  // Register offsets
  localparam logic [11:0] OFF_CH5_POS = 12'h560;
  localparam logic [11:0] OFF_CH5_NEG = 12'h564;
  localparam logic [11:0] OFF_CH5_CFG = 12'h568;
  localparam logic [11:0] OFF_CH5_LIM = 12'h56C;
  localparam logic [11:0] OFF_CH6_POS = 12'h570;
  localparam logic [11:0] OFF_CH6_NEG = 12'h574;
  localparam logic [11:0] OFF_CH6_CFG = 12'h578;
  localparam logic [11:0] OFF_CH6_LIM = 12'h57C;
  localparam logic [11:0] OFF_CH7_POS = 12'h580;
  localparam logic [11:0] OFF_CH7_NEG = 12'h584;
  localparam logic [11:0] OFF_OVERSAMPLE = 12'h5F4;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h600;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h604;
  // ========================================================================
  // Field positions and reset values
  localparam int POS_RES_LSB = 0;
  localparam int NEG_RES_LSB = 4;
  localparam int GAIN_LSB = 8;
  localparam int REF_BIT = 12;
  localparam int ACQ_LSB = 16;
  localparam int MODE_BIT = 20;
  localparam int BURST_BIT = 24;
  localparam logic [31:0] CFG_WMASK = 32'h01171733;
  localparam logic [31:0] CFG_RST = 32'h00020000;
  localparam logic [31:0] LIM_RST = 32'h7FFF8000;
  localparam logic [4:0] SEL_NC = 5'h00;
  localparam logic [4:0] SEL_AIN0 = 5'h01;
  localparam logic [4:0] SEL_AIN7 = 5'h08;
  localparam logic [4:0] SEL_VDD = 5'h09;
  localparam logic [3:0] OS_RST = 4'h0;
  localparam logic [3:0] OS_MAX = 4'h8;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // ========================================================================
  // Acquisition times in microseconds and their cycle counts
  localparam int CLK_MHZ = 125;
  localparam int ACQ_US_3 = 3;
  localparam int ACQ_US_5 = 5;
  localparam int ACQ_US_10 = 10;
  localparam int ACQ_US_15 = 15;
  localparam int ACQ_US_20 = 20;
  localparam int ACQ_US_40 = 40;
  localparam int ACQ_CYC_3 = ACQ_US_3 * CLK_MHZ;
  localparam int ACQ_CYC_5 = ACQ_US_5 * CLK_MHZ;
  localparam int ACQ_CYC_10 = ACQ_US_10 * CLK_MHZ;
  localparam int ACQ_CYC_15 = ACQ_US_15 * CLK_MHZ;
  localparam int ACQ_CYC_20 = ACQ_US_20 * CLK_MHZ;
  localparam int ACQ_CYC_40 = ACQ_US_40 * CLK_MHZ;
  // ========================================================================
  // Types
  typedef enum logic [1:0] {RES_BYPASS, RES_PULLDOWN, RES_PULLUP, RES_HALF} accb_res_e;
  typedef enum logic [2:0] {GAIN_1_6, GAIN_1_5, GAIN_1_4, GAIN_1_3, GAIN_1_2, GAIN_1, GAIN_2, GAIN_4} accb_gain_e;
  typedef enum logic [3:0] {
    RG_NONE, RG_C5P, RG_C5N, RG_C5C, RG_C5L, RG_C6P, RG_C6N, RG_C6C, RG_C6L,
    RG_C7P, RG_C7N, RG_OS, RG_STS, RG_MASK
  } accb_reg_e;
endpackage
`default_nettype wire

// ---- shared/accb_samp_if.sv ----
// Sample stream carried from the burst averager to the limit comparator.
`timescale 1ns/100ps
`default_nettype none
interface accb_samp_if;
  logic valid;
  logic [2:0] chan;
  logic signed [15:0] data;
  modport src(output valid, output chan, output data);
  modport snk(input valid, input chan, input data);
endinterface
`default_nettype wire

// ---- src/accb_burst_avg.sv ----
// Burst averager between the converter result and the data-memory stream.
`timescale 1ns/100ps
`default_nettype none
module accb_burst_avg #(
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [2:0] in_chan,
  input wire logic signed [DW-1:0] in_data,
  input wire logic burst_en,
  input wire logic [3:0] os_code,
  accb_samp_if.src out
);
  typedef enum logic {AVG_IDLE, AVG_ACC} accb_avg_e;
  accb_avg_e st_q;
  logic [8:0] cnt_q;
  logic [2:0] chan_q;
  logic signed [DW+7:0] acc_q;
  logic signed [DW+7:0] acc_d;
  logic [8:0] cnt_d;
  logic [3:0] os;
  logic bypass;
  logic fresh;
  logic done;

  // ========================================================================
  // Accumulation
  assign os = (os_code > accb_pkg::OS_MAX) ? accb_pkg::OS_MAX : os_code;
  assign bypass = !burst_en || (os == accb_pkg::OS_RST);
  // A channel change mid-burst restarts the sum rather than mixing inputs.
  assign fresh = (st_q == AVG_IDLE) || (in_chan != chan_q);
  assign acc_d = fresh ? (DW+8)'(in_data) : acc_q + (DW+8)'(in_data);
  assign cnt_d = fresh ? 9'h001 : cnt_q + 9'h001;
  assign done = (cnt_d == (9'h001 << os));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= AVG_IDLE;
      cnt_q <= 9'h000;
      chan_q <= 3'h0;
      acc_q <= '0;
    end
    else if (in_valid && !bypass)
    begin
      chan_q <= in_chan;
      acc_q <= acc_d;
      cnt_q <= done ? 9'h000 : cnt_d;
      case (st_q)
        AVG_IDLE: st_q <= done ? AVG_IDLE : AVG_ACC;
        AVG_ACC: st_q <= done ? AVG_IDLE : AVG_ACC;
        default: st_q <= AVG_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Output: a bypassed sample passes, a burst emits only its average.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out.valid <= 1'b0;
      out.chan <= 3'h0;
      out.data <= '0;
    end
    else
    begin
      out.valid <= in_valid && (bypass || done);
      if (in_valid)
      begin
        out.chan <= in_chan;
        out.data <= bypass ? in_data : DW'(acc_d >>> os);
      end
    end
  end

  a_pass_through: assert property (@(posedge clk) disable iff (!rst_n)
    in_valid && bypass |=> out.valid && out.data == $past(in_data)) else $error("bypassed sample lost");
endmodule
`default_nettype wire

// ---- src/accb_limit_cmp.sv ----
// Signed limit comparator raising low and high limit events.
`timescale 1ns/100ps
`default_nettype none
module accb_limit_cmp #(
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  accb_samp_if.snk s,
  input wire logic signed [DW-1:0] low_lim,
  input wire logic signed [DW-1:0] high_lim,
  output logic low_evt,
  output logic high_evt,
  output logic [2:0] evt_chan
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_evt <= 1'b0;
      high_evt <= 1'b0;
      evt_chan <= 3'h0;
    end
    else
    begin
      low_evt <= s.valid && (s.data < low_lim);
      high_evt <= s.valid && (s.data > high_lim);
      evt_chan <= s.chan;
    end
  end

  a_low_event: assert property (@(posedge clk) disable iff (!rst_n)
    s.valid && s.data < low_lim |=> low_evt && evt_chan == $past(s.chan)) else $error("low event missed");
  a_high_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !s.valid || s.data <= high_lim |=> !high_evt) else $error("spurious high event");
endmodule
`default_nettype wire

// ---- src/accb_top.sv ----
// Channel five to seven configuration bank with APB slave and limit events.
`timescale 1ns/100ps
`default_nettype none
module accb_top #(
  parameter int unsigned ACQ40_CYC = accb_pkg::ACQ_CYC_40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] eng_chan,
  output logic [4:0] eng_pos_sel,
  output logic [4:0] eng_neg_sel,
  output logic eng_neg_gnd,
  output logic [1:0] eng_pos_res,
  output logic [1:0] eng_neg_res,
  output logic [2:0] eng_gain,
  output logic eng_ref_quarter,
  output logic [15:0] eng_acq_cycles,
  output logic eng_burst,
  output logic [3:0] eng_os,
  input wire logic res_valid,
  input wire logic [2:0] res_chan,
  input wire logic signed [15:0] res_data,
  output logic avg_valid,
  output logic [2:0] avg_chan,
  output logic signed [15:0] avg_data,
  output logic irq
);
  logic [4:0] pos_q [0:2];
  logic [4:0] neg_q [0:2];
  logic [31:0] cfg_q [0:1];
  logic [31:0] lim_q [0:1];
  logic [3:0] os_q;
  logic [3:0] sts_q;
  logic [3:0] sts_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [3:0] set_vec;
  logic [3:0] clr_vec;
  logic [31:0] rd_d;
  logic [31:0] wr_word;
  logic [31:0] cur_cfg;
  logic [31:0] res_cfg;
  logic [31:0] cmp_lim;
  logic [1:0] eidx;
  logic [1:0] ridx;
  logic [1:0] vidx;
  logic [1:0] cidx;
  logic wr_en;
  logic low_evt;
  logic high_evt;
  logic [2:0] evt_chan;
  accb_pkg::accb_reg_e acc_reg;

  accb_samp_if samp ();

  // ========================================================================
  // Helper functions
  function automatic accb_pkg::accb_reg_e decode(input logic [11:0] a);
    case (a)
      accb_pkg::OFF_CH5_POS: decode = accb_pkg::RG_C5P;
      accb_pkg::OFF_CH5_NEG: decode = accb_pkg::RG_C5N;
      accb_pkg::OFF_CH5_CFG: decode = accb_pkg::RG_C5C;
      accb_pkg::OFF_CH5_LIM: decode = accb_pkg::RG_C5L;
      accb_pkg::OFF_CH6_POS: decode = accb_pkg::RG_C6P;
      accb_pkg::OFF_CH6_NEG: decode = accb_pkg::RG_C6N;
      accb_pkg::OFF_CH6_CFG: decode = accb_pkg::RG_C6C;
      accb_pkg::OFF_CH6_LIM: decode = accb_pkg::RG_C6L;
      accb_pkg::OFF_CH7_POS: decode = accb_pkg::RG_C7P;
      accb_pkg::OFF_CH7_NEG: decode = accb_pkg::RG_C7N;
      accb_pkg::OFF_OVERSAMPLE: decode = accb_pkg::RG_OS;
      accb_pkg::OFF_IRQ_STATUS: decode = accb_pkg::RG_STS;
      accb_pkg::OFF_IRQ_MASK: decode = accb_pkg::RG_MASK;
      default: decode = accb_pkg::RG_NONE;
    endcase
  endfunction

  // Channel number to bank slot; slot 3 means a channel this bank does not hold.
  function automatic logic [1:0] slot(input logic [2:0] ch);
    case (ch)
      3'h5: slot = 2'h0;
      3'h6: slot = 2'h1;
      3'h7: slot = 2'h2;
      default: slot = 2'h3;
    endcase
  endfunction

  // Channel seven keeps no config or limits here, so it sees the reset words.
  function automatic logic [31:0] cfg_of(input logic [1:0] i);
    cfg_of = (i < 2'h2) ? cfg_q[i[0]] : accb_pkg::CFG_RST;
  endfunction

  function automatic logic [31:0] lim_of(input logic [1:0] i);
    lim_of = (i < 2'h2) ? lim_q[i[0]] : accb_pkg::LIM_RST;
  endfunction

  function automatic logic [15:0] acq_cycles(input logic [2:0] code);
    case (code)
      3'h0: acq_cycles = 16'(accb_pkg::ACQ_CYC_3);
      3'h1: acq_cycles = 16'(accb_pkg::ACQ_CYC_5);
      3'h2: acq_cycles = 16'(accb_pkg::ACQ_CYC_10);
      3'h3: acq_cycles = 16'(accb_pkg::ACQ_CYC_15);
      3'h4: acq_cycles = 16'(accb_pkg::ACQ_CYC_20);
      default: acq_cycles = 16'(ACQ40_CYC);
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int b = 0; b < 4; b++)
    begin
      merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ========================================================================
  // APB slave: zero wait states, data prepared in the setup cycle.
  assign acc_reg = decode(paddr);
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && (acc_reg != accb_pkg::RG_NONE);
  assign wr_word = merge(32'h00000000, pwdata, pstrb);

  always_comb
  begin
    rd_d = 32'h00000000;
    case (acc_reg)
      accb_pkg::RG_C5P: rd_d[4:0] = pos_q[0];
      accb_pkg::RG_C5N: rd_d[4:0] = neg_q[0];
      accb_pkg::RG_C5C: rd_d = cfg_q[0];
      accb_pkg::RG_C5L: rd_d = lim_q[0];
      accb_pkg::RG_C6P: rd_d[4:0] = pos_q[1];
      accb_pkg::RG_C6N: rd_d[4:0] = neg_q[1];
      accb_pkg::RG_C6C: rd_d = cfg_q[1];
      accb_pkg::RG_C6L: rd_d = lim_q[1];
      accb_pkg::RG_C7P: rd_d[4:0] = pos_q[2];
      accb_pkg::RG_C7N: rd_d[4:0] = neg_q[2];
      accb_pkg::RG_OS: rd_d[3:0] = os_q;
      accb_pkg::RG_STS: rd_d[3:0] = sts_q;
      accb_pkg::RG_MASK: rd_d[3:0] = mask_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= (acc_reg == accb_pkg::RG_NONE);
    end
  end

  // ========================================================================
  // Input selection registers, five bits each.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        pos_q[i] <= accb_pkg::SEL_NC;
        neg_q[i] <= accb_pkg::SEL_NC;
      end
    end
    else if (wr_en && pstrb[0])
    begin
      case (acc_reg)
        accb_pkg::RG_C5P: pos_q[0] <= pwdata[4:0];
        accb_pkg::RG_C6P: pos_q[1] <= pwdata[4:0];
        accb_pkg::RG_C7P: pos_q[2] <= pwdata[4:0];
        accb_pkg::RG_C5N: neg_q[0] <= pwdata[4:0];
        accb_pkg::RG_C6N: neg_q[1] <= pwdata[4:0];
        accb_pkg::RG_C7N: neg_q[2] <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Configuration and limit words; reserved config bits stay zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q[0] <= accb_pkg::CFG_RST;
      cfg_q[1] <= accb_pkg::CFG_RST;
    end
    else if (wr_en && acc_reg == accb_pkg::RG_C5C)
      cfg_q[0] <= merge(cfg_q[0], pwdata, pstrb) & accb_pkg::CFG_WMASK;
    else if (wr_en && acc_reg == accb_pkg::RG_C6C)
      cfg_q[1] <= merge(cfg_q[1], pwdata, pstrb) & accb_pkg::CFG_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lim_q[0] <= accb_pkg::LIM_RST;
      lim_q[1] <= accb_pkg::LIM_RST;
    end
    else if (wr_en && acc_reg == accb_pkg::RG_C5L)
      lim_q[0] <= merge(lim_q[0], pwdata, pstrb);
    else if (wr_en && acc_reg == accb_pkg::RG_C6L)
      lim_q[1] <= merge(lim_q[1], pwdata, pstrb);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      os_q <= accb_pkg::OS_RST;
    else if (wr_en && pstrb[0] && acc_reg == accb_pkg::RG_OS)
      os_q <= pwdata[3:0];
  end

  // ========================================================================
  // Engine-facing view of the channel the sampling engine names.
  assign eidx = slot(eng_chan);
  assign cur_cfg = cfg_of(eidx);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_pos_sel <= accb_pkg::SEL_NC;
      eng_neg_sel <= accb_pkg::SEL_NC;
      eng_neg_gnd <= 1'b1;
      eng_pos_res <= accb_pkg::RES_BYPASS;
      eng_neg_res <= accb_pkg::RES_BYPASS;
      eng_gain <= accb_pkg::GAIN_1_6;
      eng_ref_quarter <= 1'b0;
      eng_acq_cycles <= 16'(accb_pkg::ACQ_CYC_3);
      eng_burst <= 1'b0;
      eng_os <= accb_pkg::OS_RST;
    end
    else
    begin
      eng_pos_sel <= (eidx == 2'h3) ? accb_pkg::SEL_NC : pos_q[eidx];
      // Single-ended mode hides the negative select so the engine grounds it.
      eng_neg_sel <= (eidx == 2'h3 || !cur_cfg[accb_pkg::MODE_BIT]) ? accb_pkg::SEL_NC : neg_q[eidx];
      eng_neg_gnd <= !cur_cfg[accb_pkg::MODE_BIT];
      eng_pos_res <= cur_cfg[accb_pkg::POS_RES_LSB +: 2];
      eng_neg_res <= cur_cfg[accb_pkg::NEG_RES_LSB +: 2];
      eng_gain <= cur_cfg[accb_pkg::GAIN_LSB +: 3];
      eng_ref_quarter <= cur_cfg[accb_pkg::REF_BIT];
      eng_acq_cycles <= acq_cycles(cur_cfg[accb_pkg::ACQ_LSB +: 3]);
      eng_burst <= cur_cfg[accb_pkg::BURST_BIT];
      eng_os <= os_q;
    end
  end

  // ========================================================================
  // Result path: burst averaging, then the limit check.
  assign ridx = slot(res_chan);
  assign res_cfg = cfg_of(ridx);
  assign vidx = res_cfg[accb_pkg::BURST_BIT] ? 2'h0 : 2'h1;

  accb_burst_avg #(.DW(16)) u_avg (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(res_valid),
    .in_chan(res_chan),
    .in_data(res_data),
    .burst_en(vidx == 2'h0),
    .os_code(os_q),
    .out(samp.src)
  );

  assign avg_valid = samp.valid;
  assign avg_chan = samp.chan;
  assign avg_data = samp.data;
  assign cidx = slot(samp.chan);
  assign cmp_lim = lim_of(cidx);

  accb_limit_cmp #(.DW(16)) u_cmp (
    .clk(pclk),
    .rst_n(presetn),
    .s(samp.snk),
    .low_lim(cmp_lim[15:0]),
    .high_lim(cmp_lim[31:16]),
    .low_evt(low_evt),
    .high_evt(high_evt),
    .evt_chan(evt_chan)
  );

  // ========================================================================
  // Sticky event status; a new event beats a same-cycle write-one clear.
  always_comb
  begin
    set_vec = 4'h0;
    if (slot(evt_chan) == 2'h0)
      set_vec[1:0] = {high_evt, low_evt};
    else if (slot(evt_chan) == 2'h1)
      set_vec[3:2] = {high_evt, low_evt};
  end

  assign clr_vec = (wr_en && acc_reg == accb_pkg::RG_STS) ? wr_word[3:0] : 4'h0;
  assign sts_d = (sts_q & ~clr_vec) | set_vec;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sts_q <= accb_pkg::IRQ_RST;
    else
      sts_q <= sts_d;
  end

  // The interrupt uses the mask being written, so it never lags a mask change.
  assign mask_d = (wr_en && pstrb[0] && acc_reg == accb_pkg::RG_MASK) ? pwdata[3:0] : mask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= accb_pkg::IRQ_RST;
    else
      mask_q <= mask_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(sts_d & mask_d);
  end

  // ========================================================================
  // Checks
  a_pos_select: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && acc_reg == accb_pkg::RG_C5P |=> pos_q[0] == $past(pwdata[4:0]))
    else $error("positive select write lost");
  a_neg_ground: assert property (@(posedge pclk) disable iff (!presetn)
    !cur_cfg[accb_pkg::MODE_BIT] |=> eng_neg_gnd && eng_neg_sel == accb_pkg::SEL_NC)
    else $error("single-ended negative input not grounded");
  a_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q[0] & ~accb_pkg::CFG_WMASK) == 32'h00000000)
    else $error("reserved config bits set");
  a_acq_map: assert property (@(posedge pclk) disable iff (!presetn)
    cur_cfg[accb_pkg::ACQ_LSB +: 3] == 3'h2 |=> eng_acq_cycles == 16'h04E2)
    else $error("acquisition time wrong");
  a_gain_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> eng_gain == $past(cur_cfg[accb_pkg::GAIN_LSB +: 3]))
    else $error("gain not passed on");
  a_limit_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb == 4'hF && acc_reg == accb_pkg::RG_C6L |=> lim_q[1] == $past(pwdata))
    else $error("limit write lost");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    set_vec[0] && clr_vec[0] |=> sts_q[0])
    else $error("event lost to clear");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(sts_q & mask_q))
    else $error("interrupt level wrong");
  a_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && acc_reg == accb_pkg::RG_NONE |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ---- tb/accb_tb.sv ----
// Self-checking bench for the channel configuration bank: registers, engine outputs, events and bursts.
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ==========================================================================
  // Stimulus and observation
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] eng_chan;
  logic [4:0] eng_pos_sel;
  logic [4:0] eng_neg_sel;
  logic eng_neg_gnd;
  logic [1:0] eng_pos_res;
  logic [1:0] eng_neg_res;
  logic [2:0] eng_gain;
  logic eng_ref_quarter;
  logic [15:0] eng_acq_cycles;
  logic eng_burst;
  logic [3:0] eng_os;
  logic res_valid;
  logic [2:0] res_chan;
  logic [15:0] res_data;
  logic avg_valid;
  logic [2:0] avg_chan;
  logic [15:0] avg_data;
  logic irq;
  logic [15:0] last_avg;
  int miscompares;
  int n_tests;
  int n_avg;
  // The long acquisition count is shortened so the table check stays quick.
  accb_top #(.ACQ40_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_chan(eng_chan), .eng_pos_sel(eng_pos_sel), .eng_neg_sel(eng_neg_sel),
    .eng_neg_gnd(eng_neg_gnd), .eng_pos_res(eng_pos_res), .eng_neg_res(eng_neg_res), .eng_gain(eng_gain),
    .eng_ref_quarter(eng_ref_quarter), .eng_acq_cycles(eng_acq_cycles), .eng_burst(eng_burst),
    .eng_os(eng_os), .res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
    .avg_valid(avg_valid), .avg_chan(avg_chan), .avg_data(avg_data), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (avg_valid === 1'b1)
    begin
      n_avg <= n_avg + 1;
      last_avg <= avg_data;
    end
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // An idle edge before each setup keeps one driver from assigning psel twice in a step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic smp(input logic [2:0] c, input logic [15:0] d);
    @(posedge pclk);
    res_valid <= 1'b1;
    res_chan <= c;
    res_data <= d;
    @(posedge pclk);
    res_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [11:0] a;
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 10; i++)
    begin
      a = 12'(32'h560 + 4 * i);
      rd(a, (a[3:0] == 4'h8) ? accb_pkg::CFG_RST : (a[3:0] == 4'hC) ? accb_pkg::LIM_RST : 32'h0);
      wr(a, 32'hFFFFFFFF);
      rd(a, (a[3:0] == 4'h8) ? accb_pkg::CFG_WMASK : (a[3:0] == 4'hC) ? 32'hFFFFFFFF : 32'h1F);
    end
    apb(1'b0, 12'h5FC, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask
  // Every code of gain, resistor, reference, acquisition and mode reaches the engine.
  task automatic t_eng;
    int acq_tab[8] = '{375, 625, 1250, 1875, 2500, 20, 20, 20};
    eng_chan <= 3'h5;
    wr(accb_pkg::OFF_CH5_POS, 32'h3);
    wr(accb_pkg::OFF_CH5_NEG, 32'h9);
    for (int k = 0; k < 8; k++)
    begin
      wr(accb_pkg::OFF_CH5_CFG, 32'((k << 16) | (k << 8) | ((k & 3) << 4) | (k & 3) | ((k & 1) << 20)
        | (((k >> 1) & 1) << 12)));
      repeat (2) @(posedge pclk);
      chk({23'h0, eng_gain, eng_pos_res, eng_neg_res, eng_ref_quarter, eng_neg_gnd},
        {23'h0, 3'(k), 2'(k & 3), 2'(k & 3), 1'((k >> 1) & 1), 1'(~k & 1)});
      chk({16'h0, eng_acq_cycles}, 32'(acq_tab[k]));
      chk({22'h0, eng_pos_sel, eng_neg_sel}, {22'h0, 5'h3, (k & 1) ? 5'h9 : 5'h0});
    end
    // Channel seven holds only its selects; the rest is the reset configuration.
    eng_chan <= 3'h7;
    repeat (2) @(posedge pclk);
    chk({9'h0, eng_pos_sel, eng_neg_gnd, eng_burst, eng_acq_cycles}, {9'h0, 5'h1F, 1'b1, 1'b0, 16'h04E2});
  endtask
  task automatic t_limit;
    wr(accb_pkg::OFF_CH5_CFG, accb_pkg::CFG_RST);
    wr(accb_pkg::OFF_OVERSAMPLE, 32'h0);
    wr(accb_pkg::OFF_CH5_LIM, 32'h0064FF9C);
    wr(accb_pkg::OFF_IRQ_MASK, 32'hF);
    smp(3'h5, 16'hFF9C);
    rd(accb_pkg::OFF_IRQ_STATUS, 32'h0);
    smp(3'h5, 16'hFF38);
    rd(accb_pkg::OFF_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    smp(3'h5, 16'h0065);
    rd(accb_pkg::OFF_IRQ_STATUS, 32'h3);
    chk({16'h0, last_avg}, 32'h0065);
    wr(accb_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(accb_pkg::OFF_IRQ_STATUS, 32'h2);
    wr(accb_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // The clear lands on the very edge at which the new low event sets its bit.
    fork
      smp(3'h5, 16'hFF38);
      begin
        @(posedge pclk);
        wr(accb_pkg::OFF_IRQ_STATUS, 32'h1);
      end
    join
    rd(accb_pkg::OFF_IRQ_STATUS, 32'h3);
  endtask
  // Four samples at oversample code 2 must leave exactly one average behind.
  task automatic t_burst;
    int na;
    wr(accb_pkg::OFF_CH6_CFG, 32'h01020000);
    wr(accb_pkg::OFF_OVERSAMPLE, 32'h2);
    eng_chan <= 3'h6;
    repeat (2) @(posedge pclk);
    chk({27'h0, eng_burst, eng_os}, 32'h12);
    na = n_avg;
    smp(3'h6, 16'h000A);
    smp(3'h6, 16'h0014);
    smp(3'h6, 16'h001E);
    smp(3'h6, 16'h0029);
    chk(32'(n_avg - na), 32'h1);
    chk({16'h0, last_avg}, 32'h0019);
    chk({29'h0, avg_chan}, 32'h6);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, eng_chan, res_valid, res_chan, res_data} = '0;
    pstrb = 4'hF;
    miscompares = 0;
    n_tests = 0;
    n_avg = 0;
    last_avg = 16'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_eng();
    t_limit();
    t_burst();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
